// file: bench/ctrl_model.sv
// behavioural memory controller that drives the device link pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_model import gddr_pkg::*; #(
  parameter int FAW_CK = 10,
  parameter int PDEX_CK = 2
) (
  // link pins toward the device
  output logic o_ck,
  output logic o_cke,
  output logic [3:0] o_cmd,
  output logic o_scope,
  output logic [BANK_W-1:0] o_bank,
  output logic o_wstrobe,
  output logic [DQ_W-1:0] o_dq
);
  int lcyc = 0;
  int active = 0;
  int act_t[$];
  // link clock runs free, the device needs it stable in power-down too
  initial begin
    o_ck = 1'b0;
    o_cke = 1'b1;
    o_cmd = CMD_NOP;
    o_scope = 1'b0;
    o_bank = '0;
    o_wstrobe = 1'b1;
    o_dq = '1;
    #7.3;
    forever #40 o_ck = ~o_ck;
  end
  // rise counter for the activate window
  always @(posedge o_ck) lcyc <= lcyc + 1;
  // one command for one link cycle, pins change at the falling edge
  task automatic cmd(input logic [3:0] c, input logic sc, input logic [BANK_W-1:0] b);
    @(negedge o_ck);
    while (c == CMD_ACT && act_t.size() == 4 && lcyc + 1 - act_t[0] < FAW_CK)
      @(negedge o_ck);
    if (c == CMD_ACT && act_t.size() == 4)
      void'(act_t.pop_front());
    if (c == CMD_ACT)
      act_t.push_back(lcyc + 1);
    o_cmd = c;
    o_scope = sc;
    o_bank = b;
    @(negedge o_ck);
    o_cmd = CMD_NOP;
    o_scope = ~sc;
    o_bank = ~b; // don't-care now, so no stale value is left standing
  endtask : cmd
  // clock enable moves at a falling edge, burst or not, then waits exit delay
  task automatic set_cke(input logic v);
    @(negedge o_ck);
    o_cke = v;
    repeat (PDEX_CK + 1) @(negedge o_ck);
  endtask : set_cke
  // preamble, four words on successive strobe edges, rise first, postamble
  task automatic burst(input int wl, input logic [4*DQ_W-1:0] w);
    repeat (wl) @(posedge o_ck);
    active++;
    o_wstrobe = 1'b0;
    #20;
    for (int i = 0; i < 4; i++) begin
      o_dq = w[i*DQ_W +: DQ_W];
      #20 o_wstrobe = ~i[0];
      #20;
    end
    #10;
    if (active == 1)
      o_dq = '1; // termination pulls the released lines high
    #10;
    if (active == 1)
      o_wstrobe = 1'b1;
    active--;
  endtask : burst
  // stray strobe edges and data with no burst pending
  task automatic junk();
    for (int i = 0; i < 4; i++) begin
      #20 o_dq = ~o_dq;
      #20 o_wstrobe = ~o_wstrobe;
    end
  endtask : junk
endmodule : ctrl_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench: device core against a queue model and a controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top import gddr_pkg::*;;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [LAT_W-1:0] i_write_latency = 4'h1;
  logic [LAT_W-1:0] i_read_latency = 4'h2;
  logic i_wr_ready = 1'b0;
  logic hold_drain = 1'b0;
  logic exp_pd = 1'b0;
  logic exp_ovr = 1'b0;
  logic [NUM_BANKS-1:0] exp_banks = '0;
  logic [DQ_W-1:0] exp_q[$];
  int bad_count = 0;
  int cmp_count = 0;
  wire link_ck, cke, scope, wstrobe;
  wire [3:0] cmd_pins;
  wire [BANK_W-1:0] bank;
  wire [DQ_W-1:0] dq;
  logic rstrobe, rstrobe_oe, o_wr_valid, powerdown, act_pd, overrun, dq_oe;
  logic [DQ_W-1:0] o_wr_data;
  logic [NUM_BANKS-1:0] o_open_banks;
  always #2 i_core_clk = ~i_core_clk;
  ctrl_model #(.FAW_CK(10), .PDEX_CK(2)) i_ctrl (.o_ck(link_ck), .o_cke(cke),
    .o_cmd(cmd_pins), .o_scope(scope), .o_bank(bank), .o_wstrobe(wstrobe), .o_dq(dq));
  gddr_dev_core i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_link_ck(link_ck),
    .i_cke(cke), .i_cs_n(cmd_pins[3]), .i_ras_n(cmd_pins[2]), .i_cas_n(cmd_pins[1]),
    .i_we_n(cmd_pins[0]), .i_precharge_scope_bit(scope), .i_bank_select(bank),
    .i_write_strobe(wstrobe), .i_dq(dq), .o_read_strobe(rstrobe),
    .o_read_strobe_oe(rstrobe_oe), .o_dq_oe(dq_oe), .i_write_latency(i_write_latency),
    .i_read_latency(i_read_latency), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready),
    .o_wr_data(o_wr_data), .o_open_banks(o_open_banks), .o_powerdown(powerdown),
    .o_active_powerdown(act_pd), .o_write_overrun(overrun));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // drain stalls at random unless the fill test holds it off
  always @(posedge i_core_clk) begin
    i_wr_ready <= hold_drain ? 1'b0 : 1'($urandom_range(1, 0));
    if (!i_sys_rst && o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check("surplus word", 1, 0);
      else
        check("write word", o_wr_data, exp_q.pop_front());
    end
  end
  task automatic settle();
    repeat (12) @(posedge i_core_clk);
  endtask : settle
  task automatic do_cmd(input logic [3:0] c, input logic sc, input logic [BANK_W-1:0] b);
    i_ctrl.cmd(c, sc, b);
    if (!exp_pd && c == CMD_ACT)
      exp_banks[b] = 1'b1;
    if (!exp_pd && c == CMD_PRE)
      exp_banks = sc ? '0 : exp_banks & ~(8'h01 << b);
    settle();
  endtask : do_cmd
  // model pushes words at issue; a full buffer drops them while drain is held
  task automatic do_write(input logic sc, input logic [BANK_W-1:0] b, input int wl);
    logic [4*DQ_W-1:0] w;
    w = {$urandom, $urandom, $urandom, $urandom};
    @(posedge i_core_clk);
    i_write_latency <= LAT_W'(wl);
    for (int i = 0; i < 4; i++)
      if (!hold_drain || exp_q.size() < FIFO_DEPTH)
        exp_q.push_back(w[i*DQ_W +: DQ_W]);
      else
        exp_ovr = 1'b1;
    i_ctrl.cmd(CMD_WRITE, sc, b);
    fork
      begin
        i_ctrl.burst(wl, w);
        if (sc)
          exp_banks[b] = 1'b0;
      end
    join_none
  endtask : do_write
  task automatic do_read(input int rl);
    realtime t0;
    int n;
    int falls;
    logic prev;
    @(posedge i_core_clk);
    i_read_latency <= LAT_W'(rl);
    i_ctrl.cmd(CMD_READ, 1'b0, 3'h0);
    t0 = $realtime - 40.0;
    n = 0;
    falls = 0;
    while (rstrobe_oe !== 1'b1 && n < 400) begin
      @(posedge i_core_clk);
      n++;
    end
    check("strobe lead", int'(($realtime - t0 - 40.0) / 80.0), rl);
    check("strobe starts high", rstrobe, 1'b1);
    while (rstrobe_oe === 1'b1 && n < 400) begin
      prev = rstrobe;
      @(posedge i_core_clk);
      n++;
      if (prev === 1'b1 && rstrobe === 1'b0 && rstrobe_oe === 1'b1)
        falls++;
    end
    check("strobe falls", falls, 2);
    check("read in time", n < 400, 1'b1);
  endtask : do_read
  task automatic pdown(input logic [BANK_W-1:0] b);
    i_ctrl.set_cke(1'b0);
    exp_pd = 1'b1;
    check("power-down", powerdown, 1'b1);
    check("active power-down", act_pd, |exp_banks);
    do_cmd(CMD_ACT, 1'b0, b);
    check("banks frozen", o_open_banks, exp_banks);
    i_ctrl.set_cke(1'b1);
    exp_pd = 1'b0;
    check("power-down exit", powerdown, 1'b0);
  endtask : pdown
  initial begin
    void'($urandom(32'h4CE4));
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    for (int b = 0; b < NUM_BANKS; b++)
      do_cmd(CMD_ACT, 1'b0, BANK_W'(b));
    check("all open", o_open_banks, exp_banks);
    for (int i = 1; i <= 4; i++) begin
      do_write(i[0], BANK_W'(i), i);
      repeat (i + 4) @(posedge link_ck);
      check("autoprecharge", o_open_banks, exp_banks);
    end
    do_write(1'b0, 3'h4, 3);
    do_write(1'b1, 3'h6, 3);
    repeat (9) @(posedge link_ck);
    check("back-to-back", o_open_banks, exp_banks);
    for (int r = 1; r <= 3; r++)
      do_read(r);
    do_cmd(CMD_PRE, 1'b0, BANK_W'($urandom_range(7, 2)));
    check("precharge one", o_open_banks, exp_banks);
    pdown(3'h1);
    do_cmd(CMD_PRE, 1'b1, BANK_W'($urandom));
    check("precharge all", o_open_banks, exp_banks);
    pdown(3'h2);
    do_cmd(CMD_ACT, 1'b0, 3'h5);
    hold_drain <= 1'b1;
    do_write(1'b0, 3'h5, 2);
    do_write(1'b0, 3'h5, 2);
    repeat (10) @(posedge link_ck);
    check("overrun flag", overrun, exp_ovr);
    check("buffer full", o_wr_valid, 1'b1);
    hold_drain <= 1'b0;
    repeat (60) @(posedge i_core_clk);
    check("drained", exp_q.size(), 0);
    i_sys_rst <= 1'b1;
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    exp_banks = '0;
    @(posedge i_core_clk);
    check("reset overrun", overrun, 1'b0);
    check("reset banks", o_open_banks, exp_banks);
    settle();
    i_ctrl.junk();
    repeat (40) @(posedge i_core_clk);
    check("stray words", o_wr_valid, 1'b0);
    check("data lines undriven", dq_oe, 1'b0);
    tally_and_finish();
  end
  // watchdog: the sequence needs well under a tenth of this span
  initial begin
    #150000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire

// file: logic/gddr_dev_core.sv
// device-side command, write capture, bank, power-down and read strobe logic
`timescale 1ns/1ps
`default_nettype none
module gddr_dev_core import gddr_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // link pins from the controller
  input wire logic i_link_ck,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_precharge_scope_bit,
  input wire logic [BANK_W-1:0] i_bank_select,
  input wire logic i_write_strobe,
  input wire logic [DQ_W-1:0] i_dq,
  // link pins toward the controller
  output logic o_read_strobe,
  output logic o_read_strobe_oe,
  output logic o_dq_oe,
  // configuration
  input wire logic [LAT_W-1:0] i_write_latency,
  input wire logic [LAT_W-1:0] i_read_latency,
  // captured write data
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [DQ_W-1:0] o_wr_data,
  // status
  output logic [NUM_BANKS-1:0] o_open_banks,
  output logic o_powerdown,
  output logic o_active_powerdown,
  output logic o_write_overrun
);
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, f_q;
  logic [PIN_W-1:0] agree;
  logic ck_rise, ck_fall, ws_rise, ws_edge;
  logic [3:0] cmd;
  logic is_nop, cmd_ok, do_act, do_read, do_write, do_pre;
  logic [BANK_W-1:0] bank;
  logic pd_q;
  logic [NUM_BANKS-1:0] open_q;
  logic [BANK_W+1:0] wpipe_q [WL_MAX];
  logic [BANK_W+1:0] tap;
  logic [LAT_W-1:0] wl_idx;
  logic [LAT_W-1:0] rem_q;
  logic [1:0] idx_q;
  logic take, last_take;
  logic [BANK_W:0] head_q, next_q;
  logic push_q;
  logic [DQ_W-1:0] data_q;
  rs_state_e rs_q;
  logic [LAT_W-1:0] rs_cnt_q;
  logic [1:0] rs_tog_q;
  logic rs_out_q;
  stream_if #(.W(DQ_W)) wr_s ();

  assign pins = {i_dq, i_write_strobe, i_bank_select, i_precharge_scope_bit,
                 i_we_n, i_cas_n, i_ras_n, i_cs_n, i_cke, i_link_ck};

  // three-stage sampling; left without reset so the pins flow through during reset
  always_ff @(posedge i_core_clk) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // per-pin filter: hold the last agreed level
  for (genvar g = 0; g < PIN_W; g++) begin : g_filt
    assign agree[g] = (s2_q[g] == s3_q[g]);
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) f_q[g] <= s3_q[g]; // track idle levels, so no false edge after reset
      else if (agree[g]) f_q[g] <= s3_q[g];
    end
  end

  // edges of the sampled link clock and write strobe
  assign ck_rise = agree[PIN_CK] & s3_q[PIN_CK] & ~f_q[PIN_CK];
  assign ck_fall = agree[PIN_CK] & ~s3_q[PIN_CK] & f_q[PIN_CK];
  assign ws_edge = agree[PIN_WSTROBE] & (s3_q[PIN_WSTROBE] != f_q[PIN_WSTROBE]);
  assign ws_rise = ws_edge & s3_q[PIN_WSTROBE];

  // command decode, registered on a link clock rise
  assign cmd = {f_q[PIN_CS_N], f_q[PIN_RAS_N], f_q[PIN_CAS_N], f_q[PIN_WE_N]};
  assign bank = f_q[PIN_BANK_LO +: BANK_W];
  assign is_nop = f_q[PIN_CS_N] | (cmd == CMD_NOP);
  assign cmd_ok = ck_rise & ~pd_q & f_q[PIN_CKE]; // inputs are dead while powered down
  assign do_act = cmd_ok & (cmd == CMD_ACT);
  assign do_read = cmd_ok & (cmd == CMD_READ);
  assign do_write = cmd_ok & (cmd == CMD_WRITE);
  assign do_pre = cmd_ok & (cmd == CMD_PRE);

  // power-down entry on low clock enable, exit on high with nop or deselect
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pd_q <= 1'b0;
    end else if (ck_rise) begin
      if (!pd_q && !f_q[PIN_CKE]) pd_q <= 1'b1;
      else if (pd_q && f_q[PIN_CKE] && is_nop) pd_q <= 1'b0;
    end
  end

  // write latency pipeline of {valid, autoprecharge, bank}, shifted per link cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < WL_MAX; i++) wpipe_q[i] <= '0;
    end else if (ck_rise) begin
      wpipe_q[0] <= {do_write, f_q[PIN_SCOPE], bank};
      for (int i = 1; i < WL_MAX; i++) wpipe_q[i] <= wpipe_q[i-1];
    end
  end

  // a latency of zero is not supported and acts as one
  assign wl_idx = (i_write_latency == '0) ? '0 : i_write_latency - 1'b1;
  assign tap = ck_rise ? wpipe_q[wl_idx] : '0;

  // burst capture: first word only on a strobe rise, then every strobe edge
  assign take = (rem_q != '0) & ws_edge & (ws_rise | (idx_q != '0));
  assign last_take = take & (idx_q == 2'(BURST_LEN - 1));

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rem_q <= '0;
      idx_q <= '0;
    end else begin
      rem_q <= rem_q + (tap[BANK_W+1] ? LAT_W'(BURST_LEN) : '0) - LAT_W'(take);
      if (take) idx_q <= idx_q + 1'b1;
    end
  end

  // bursts in flight: at most one current and one queued behind it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      head_q <= '0;
      next_q <= '0;
    end else if (tap[BANK_W+1]) begin
      if (rem_q == '0 || (last_take && rem_q == LAT_W'(1))) head_q <= tap[BANK_W:0];
      else next_q <= tap[BANK_W:0];
    end else if (last_take) begin
      head_q <= next_q;
    end
  end

  // captured words go to the buffer; a full buffer drops and flags the word
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      push_q <= 1'b0;
      data_q <= '0;
      o_write_overrun <= 1'b0;
    end else begin
      push_q <= take;
      if (take) data_q <= s3_q[PIN_DQ_LO +: DQ_W];
      if (push_q && !wr_s.ready) o_write_overrun <= 1'b1;
    end
  end

  assign wr_s.valid = push_q;
  assign wr_s.data = data_q;

  write_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .fill(wr_s),
    .o_valid(o_wr_valid),
    .i_ready(i_wr_ready),
    .o_data(o_wr_data)
  );

  // per-bank open row: activate opens, precharge or autoprecharge closes
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        open_q[b] <= 1'b0;
      end else if (do_act && bank == BANK_W'(b)) begin
        open_q[b] <= 1'b1;
      end else if (do_pre && (f_q[PIN_SCOPE] || bank == BANK_W'(b))) begin
        open_q[b] <= 1'b0;
      end else if (last_take && head_q[BANK_W] && head_q[BANK_W-1:0] == BANK_W'(b)) begin
        open_q[b] <= 1'b0;
      end
    end
  end

  // read strobe: high from the latency rise, falling on the next clock fall
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rs_q <= RS_IDLE;
      rs_cnt_q <= '0;
      rs_tog_q <= '0;
      rs_out_q <= 1'b0;
    end else begin
      case (rs_q)
        RS_IDLE: begin
          if (do_read) begin
            rs_cnt_q <= i_read_latency;
            rs_q <= RS_WAIT;
          end
        end
        RS_WAIT: begin
          if (ck_rise) begin
            if (rs_cnt_q <= LAT_W'(1)) begin
              rs_out_q <= 1'b1;
              rs_tog_q <= '0;
              rs_q <= RS_DRIVE;
            end else begin
              rs_cnt_q <= rs_cnt_q - 1'b1;
            end
          end
        end
        RS_DRIVE: begin
          if (ck_rise || ck_fall) begin
            rs_out_q <= ~rs_out_q;
            rs_tog_q <= rs_tog_q + 1'b1;
            if (rs_tog_q == 2'(BURST_LEN - 1)) begin
              rs_out_q <= 1'b0;
              rs_q <= RS_IDLE;
            end
          end
        end
        default: rs_q <= RS_IDLE;
      endcase
    end
  end

  // outputs; the device never drives data on writes or after a burst
  assign o_read_strobe = rs_out_q;
  assign o_read_strobe_oe = (rs_q == RS_DRIVE);
  assign o_dq_oe = 1'b0;
  assign o_open_banks = open_q;
  assign o_powerdown = pd_q;
  assign o_active_powerdown = pd_q & (|open_q);

  // checks
  sequence s_pd_enter;
    ck_rise && !pd_q && !f_q[PIN_CKE];
  endsequence
  sequence s_pd_leave;
    ck_rise && pd_q && f_q[PIN_CKE] && is_nop;
  endsequence

  chk_pd_entry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_pd_enter |=> o_powerdown ##0 (o_active_powerdown == (|o_open_banks)))
    else $error("power-down not entered on low clock enable");
  chk_pd_exit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_pd_leave |=> !o_powerdown)
    else $error("power-down not left on clock enable high with nop");
  chk_pd_deaf: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    pd_q && ck_rise |=> $stable(o_open_banks) && $stable(rem_q))
    else $error("command acted on during power-down");
  chk_pre_all: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    do_pre && f_q[PIN_SCOPE] |=> o_open_banks == '0)
    else $error("precharge all left a bank open");
  chk_pre_one: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    do_pre && !f_q[PIN_SCOPE] |=> !o_open_banks[$past(bank)])
    else $error("single precharge left its bank open");
  chk_idle_ignore: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    rem_q == '0 && !tap[BANK_W+1] && !push_q |=> !$rose(o_wr_valid) && !o_dq_oe
      && $stable(o_write_overrun))
    else $error("data taken outside a write burst");
  chk_first_rise: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    take && idx_q == '0 |-> ws_rise ##1 push_q)
    else $error("burst started on a falling strobe edge");
  chk_rs_pre: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_read_strobe_oe) |-> o_read_strobe)
    else $error("read strobe not high when it starts");
  chk_rs_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_read_strobe_oe && !ck_rise && !ck_fall |=> $stable(o_read_strobe))
    else $error("read strobe moved between clock edges");
  chk_rs_first_fall: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_read_strobe_oe && o_read_strobe && ck_fall |=> !o_read_strobe)
    else $error("read strobe did not fall on the clock fall");
  chk_ap_close: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    last_take && head_q[BANK_W] && !do_act |=> !o_open_banks[$past(head_q[BANK_W-1:0])])
    else $error("autoprecharge did not close the bank");
endmodule : gddr_dev_core
`default_nettype wire

// file: logic/write_fifo.sv
// small synchronous fifo for captured write data
`timescale 1ns/1ps
`default_nettype none
module write_fifo import gddr_pkg::*; #(
  parameter int W = DQ_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // filling side
  stream_if.snk fill,
  // draining side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign fill.ready = (count_q != (AW+1)'(DEPTH));
  assign o_valid = (count_q != '0);
  assign o_data = mem_q[rd_ptr_q];
  assign push = fill.valid & fill.ready;
  assign pop = o_valid & i_ready;

  // storage array, written only on push
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= fill.data;
    end
  end

  // pointers wrap at the power-of-two depth
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : write_fifo
`default_nettype wire

// file: pkg/gddr_pkg.sv
// shared constants, command codes and state types of the dram device core
package gddr_pkg;
  // widths and depths
  localparam int DQ_W = 32;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int BURST_LEN = 4;
  localparam int LAT_W = 4;
  localparam int WL_MAX = 16;
  localparam int FIFO_DEPTH = 4;
  // positions of the link pins in the sampled vector
  localparam int PIN_CK = 0;
  localparam int PIN_CKE = 1;
  localparam int PIN_CS_N = 2;
  localparam int PIN_RAS_N = 3;
  localparam int PIN_CAS_N = 4;
  localparam int PIN_WE_N = 5;
  localparam int PIN_SCOPE = 6;
  localparam int PIN_BANK_LO = 7;
  localparam int PIN_WSTROBE = 10;
  localparam int PIN_DQ_LO = 11;
  localparam int PIN_W = PIN_DQ_LO + DQ_W;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  // read strobe sequencer
  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_WAIT = 3'h2,
    RS_DRIVE = 3'h4
  } rs_state_e;
endpackage : gddr_pkg

// file: pkg/stream_if.sv
// valid/ready word stream between the core and its write buffer
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(
  parameter int W = 32
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire
